// file: rtl/psirq_pkg.sv
package psirq_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LIVE = 6'h11;
    localparam logic [IDX_W-1:0] IDX_MASK = 6'h12;
    localparam logic [IDX_W-1:0] IDX_EVENT = 6'h13;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h18;
    localparam logic [REG_W-1:0] LIVE_RST = 16'h0000;
    localparam logic [REG_W-1:0] MASK_RST = 16'h0000;
    localparam logic [REG_W-1:0] EVENT_RST = 16'h0000;
    localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [REG_W-1:0] CTRL_WMASK = 16'h2001;
    localparam int B_GLOBAL_EN = 0;
    localparam int B_POLARITY = 13;
    localparam int ST_PAGE = 12;
    localparam logic [1:0] RATE_10 = 2'h0;
    localparam logic [1:0] RATE_100 = 2'h1;
    localparam logic [1:0] RATE_1000 = 2'h2;
    localparam int EV_NEG = 15;
    localparam int EV_RATE = 14;
    localparam int EV_DUPLEX = 13;
    localparam int EV_PAGE = 12;
    localparam int EV_ANDONE = 11;
    localparam int EV_LINK = 10;
    localparam int EV_ENERGY = 9;
    localparam int EV_FCAR = 8;
    localparam int EV_CONV = 7;
    localparam int EV_MDIX = 6;
    localparam int EV_SOPT = 5;
    localparam int EV_SLEEP = 4;
    localparam int EV_WAKE = 3;
    localparam int EV_GMII = 2;
    localparam int EV_POL = 1;
    localparam int EV_JAB = 0;
    // bits that follow their source instead of latching
    localparam logic [REG_W-1:0] EV_LIVE_MASK = 16'h020C;

    typedef struct packed {
        logic [1:0] rate;
        logic full_half;
        logic an_enabled;
        logic an_done;
        logic an_active;
        logic link_up;
        logic mdix_cd;
        logic mdix_ab;
        logic downshift;
        logic sleep;
        logic [3:0] wire_pol;
        logic pol10;
        logic babble;
    } psirq_phy_s;

    typedef struct packed {
        logic neg_fault;
        logic page_rx;
        logic false_carrier;
        logic converter_fault;
        logic speed_opt;
        logic energy_fault;
        logic wake;
        logic gmii_err;
    } psirq_evt_s;
endpackage

// file: rtl/psirq_bit_latch.sv
`timescale 1ns/1ps
module psirq_bit_latch #(
    parameter int W = 16,
    parameter logic [W-1:0] LIVE_MASK = '0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] q_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (LIVE_MASK[i]) begin : g_live
                always_ff @(posedge clk_in) begin
                    if (!nrst_in) begin
                        q_out[i] <= 1'b0;
                    end else begin
                        q_out[i] <= set_in[i];
                    end
                end
            end else begin : g_hold
                // set wins over a clear in the same cycle
                always_ff @(posedge clk_in) begin
                    if (!nrst_in) begin
                        q_out[i] <= 1'b0;
                    end else begin
                        q_out[i] <= set_in[i] | (q_out[i] & ~clr_in[i]);
                    end
                end
            end
        end
    endgenerate
endmodule

// file: rtl/psirq_top.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// R01: rate field codes 10/100/1000 ascending
// R02: duplex bit, one means full
// R03: page bit latches, clears on read
// R04: settled when negotiation done or disabled
// R05: live link up bit
// R06: downshift masking flag during negotiation only
// R07: sleep bit, one means sleeping
// R08: gigabit pair polarity D,C,B,A field
// R09: 10 Mb/s polarity, one means normal
// R10: babble in lowest live bit
// R11: interrupt needs event, enable, global enable
// R12: sixteen enable bits match event positions
// R13: event since last read sets bit
// R14: events latch regardless of enables
// R15: latched bit clears only once returned
// R16: negotiation fault in top event bit
// R17: rate change latches event
// R18: duplex change latches event
// R19: link change latches event
// R20: converter buffer fault latches event
// R21: energy saving fault event bit
// R22: wake packet event bit
// R23: interrupt polarity from config bit
// R24: event during clearing read survives
module psirq_top (
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    input wire logic [psirq_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic [psirq_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
    output logic [psirq_pkg::DATA_W-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire psirq_pkg::psirq_phy_s PHY_STATE_IN,
    input wire psirq_pkg::psirq_evt_s PHY_EVENT_IN,
    output logic IRQ_OUT
);
    import psirq_pkg::*;

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    logic req_w;
    logic accept_w;
    logic capture_w;
    logic ack_q;
    logic [IDX_W-1:0] idx_w;

    assign req_w = AVS_READ_IN | AVS_WRITE_IN;
    assign accept_w = req_w & ack_q;
    assign capture_w = AVS_READ_IN & ~ack_q;
    assign idx_w = AVS_ADDRESS_IN[ADDR_W-1:2];
    assign AVS_WAITREQUEST_OUT = req_w & ~ack_q;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            ack_q <= 1'b0;
        end else if (accept_w) begin
            ack_q <= 1'b0;
        end else if (req_w) begin
            ack_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic [REG_W-1:0] mask_q;
    logic [REG_W-1:0] ctrl_q;
    logic [REG_W-1:0] be_w;
    logic wr_mask_w;
    logic wr_ctrl_w;

    assign be_w = {{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    assign wr_mask_w = accept_w & AVS_WRITE_IN & (idx_w == IDX_MASK);
    assign wr_ctrl_w = accept_w & AVS_WRITE_IN & (idx_w == IDX_CTRL);

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            mask_q <= MASK_RST;
        end else if (wr_mask_w) begin
            mask_q <= (mask_q & ~be_w) | (AVS_WRITEDATA_IN[REG_W-1:0] & be_w); // R12
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl_w) begin
            ctrl_q <= (ctrl_q & ~(be_w & CTRL_WMASK))
                | (AVS_WRITEDATA_IN[REG_W-1:0] & be_w & CTRL_WMASK);
        end
    end

    // ----------------------------------------
    // change detection
    // ----------------------------------------
    psirq_phy_s prev_q;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            prev_q <= '0;
        end else begin
            prev_q <= PHY_STATE_IN;
        end
    end

    logic [REG_W-1:0] ev_set_w;
    logic [REG_W-1:0] ev_clr_w;
    logic [REG_W-1:0] event_q;

    always_comb begin
        ev_set_w = '0;
        ev_set_w[EV_NEG] = PHY_EVENT_IN.neg_fault; // R16
        ev_set_w[EV_RATE] = PHY_STATE_IN.rate != prev_q.rate; // R17
        ev_set_w[EV_DUPLEX] = PHY_STATE_IN.full_half != prev_q.full_half; // R18
        ev_set_w[EV_PAGE] = PHY_EVENT_IN.page_rx;
        ev_set_w[EV_ANDONE] = PHY_STATE_IN.an_done & ~prev_q.an_done;
        ev_set_w[EV_LINK] = PHY_STATE_IN.link_up != prev_q.link_up; // R19
        ev_set_w[EV_ENERGY] = PHY_EVENT_IN.energy_fault; // R21
        ev_set_w[EV_FCAR] = PHY_EVENT_IN.false_carrier;
        ev_set_w[EV_CONV] = PHY_EVENT_IN.converter_fault; // R20
        ev_set_w[EV_MDIX] = (PHY_STATE_IN.mdix_cd != prev_q.mdix_cd)
            | (PHY_STATE_IN.mdix_ab != prev_q.mdix_ab);
        ev_set_w[EV_SOPT] = PHY_EVENT_IN.speed_opt;
        ev_set_w[EV_SLEEP] = PHY_STATE_IN.sleep != prev_q.sleep;
        ev_set_w[EV_WAKE] = PHY_EVENT_IN.wake; // R22
        ev_set_w[EV_GMII] = PHY_EVENT_IN.gmii_err;
        ev_set_w[EV_POL] = PHY_STATE_IN.pol10 != prev_q.pol10;
        ev_set_w[EV_JAB] = PHY_STATE_IN.babble & ~prev_q.babble;
    end

    // ----------------------------------------
    // latched bits
    // ----------------------------------------
    logic [REG_W-1:0] snap_ev_q;
    logic snap_pg_q;
    logic page_q;
    logic rd_done_w;

    assign rd_done_w = accept_w & AVS_READ_IN;
    assign ev_clr_w = rd_done_w ? snap_ev_q : '0; // R15

    // every event except energy fault, wake and GMII error (live bits) latches, enabled or not
    psirq_bit_latch #(
        .W(REG_W),
        .LIVE_MASK(EV_LIVE_MASK)
    ) u_event (
        .clk_in(MCLK_IN),
        .nrst_in(NRST_IN),
        .set_in(ev_set_w), // R13 R14
        .clr_in(ev_clr_w), // R24
        .q_out(event_q)
    );

    psirq_bit_latch #(
        .W(1),
        .LIVE_MASK(1'b0)
    ) u_page (
        .clk_in(MCLK_IN),
        .nrst_in(NRST_IN),
        .set_in(PHY_EVENT_IN.page_rx),
        .clr_in(rd_done_w & snap_pg_q), // R03
        .q_out(page_q)
    );

    // ----------------------------------------
    // live status word
    // ----------------------------------------
    logic [REG_W-1:0] live_w;
    logic giga_w;

    assign giga_w = PHY_STATE_IN.link_up & (PHY_STATE_IN.rate == RATE_1000);

    always_comb begin
        live_w = LIVE_RST;
        live_w[15:14] = PHY_STATE_IN.rate; // R01
        live_w[13] = PHY_STATE_IN.full_half; // R02
        live_w[ST_PAGE] = page_q; // R03
        live_w[11] = ~PHY_STATE_IN.an_enabled | PHY_STATE_IN.an_done; // R04
        live_w[10] = PHY_STATE_IN.link_up; // R05
        live_w[9] = PHY_STATE_IN.mdix_cd;
        live_w[8] = PHY_STATE_IN.mdix_ab;
        live_w[7] = PHY_STATE_IN.downshift & PHY_STATE_IN.an_active; // R06
        live_w[6] = PHY_STATE_IN.sleep; // R07
        live_w[5:2] = giga_w ? PHY_STATE_IN.wire_pol : 4'h0; // R08
        live_w[1] = PHY_STATE_IN.pol10; // R09
        live_w[0] = PHY_STATE_IN.babble; // R10
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [REG_W-1:0] rd_mux_w;

    always_comb begin
        case (idx_w)
            IDX_LIVE: rd_mux_w = live_w;
            IDX_MASK: rd_mux_w = mask_q;
            IDX_EVENT: rd_mux_w = event_q;
            IDX_CTRL: rd_mux_w = ctrl_q;
            default: rd_mux_w = '0;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            AVS_READDATA_OUT <= '0;
        end else if (capture_w) begin
            AVS_READDATA_OUT <= {{(DATA_W-REG_W){1'b0}}, rd_mux_w};
        end
    end

    // remembers exactly what was returned, so only those bits clear
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            snap_ev_q <= '0;
            snap_pg_q <= 1'b0;
        end else if (capture_w) begin
            snap_ev_q <= (idx_w == IDX_EVENT) ? event_q : '0;
            snap_pg_q <= (idx_w == IDX_LIVE) & page_q;
        end
    end

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    logic irq_act_w;

    assign irq_act_w = ctrl_q[B_GLOBAL_EN] & (|(event_q & mask_q)); // R11

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= irq_act_w ^ ctrl_q[B_POLARITY]; // R23
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic rd_live_w;

    assign rd_live_w = capture_w & (idx_w == IDX_LIVE);

    a_rate_code: assert property ( // R01
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_live_w |=> AVS_READDATA_OUT[15:14] == $past(PHY_STATE_IN.rate)
    ) else $error("rate field wrong");

    a_full_half: assert property ( // R02
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_live_w |=> AVS_READDATA_OUT[13] == $past(PHY_STATE_IN.full_half)
    ) else $error("duplex bit wrong");

    a_page_hold: assert property ( // R03
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_EVENT_IN.page_rx |=> page_q
    ) else $error("page bit not latched");

    a_settled_bit: assert property ( // R04
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_live_w && PHY_STATE_IN.an_enabled && !PHY_STATE_IN.an_done
        |=> !AVS_READDATA_OUT[11]
    ) else $error("settled set while negotiating");

    a_mask_write: assert property ( // R12
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        wr_mask_w && AVS_BYTEENABLE_IN[1:0] == 2'h3
        |=> mask_q == $past(AVS_WRITEDATA_IN[REG_W-1:0])
    ) else $error("mask write lost");

    a_irq_global: assert property ( // R11
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        !ctrl_q[B_GLOBAL_EN] |=> IRQ_OUT == $past(ctrl_q[B_POLARITY])
    ) else $error("interrupt active without global enable");

    a_irq_fires: assert property ( // R23
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        ctrl_q[B_GLOBAL_EN] && (event_q & mask_q) != '0
        |=> IRQ_OUT != $past(ctrl_q[B_POLARITY])
    ) else $error("interrupt level wrong");

    a_rate_event: assert property ( // R17
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_STATE_IN.rate != prev_q.rate |=> event_q[EV_RATE]
    ) else $error("rate change not latched");

    a_link_event: assert property ( // R19
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_STATE_IN.link_up != prev_q.link_up |=> event_q[EV_LINK]
    ) else $error("link change not latched");

    a_set_wins: assert property ( // R24
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_done_w && PHY_EVENT_IN.neg_fault |=> event_q[EV_NEG]
    ) else $error("event lost on clearing read");

    a_clear_read: assert property ( // R15
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_done_w && snap_ev_q[EV_CONV] && !PHY_EVENT_IN.converter_fault
        |=> !event_q[EV_CONV]
    ) else $error("returned bit not cleared");

    a_hold_unread: assert property ( // R13
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        event_q[EV_DUPLEX] && !rd_done_w |=> event_q[EV_DUPLEX]
    ) else $error("event bit dropped without read");

    a_duplex_event: assert property ( // R18
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_STATE_IN.full_half != prev_q.full_half |=> event_q[EV_DUPLEX]
    ) else $error("duplex change not latched");

    a_neg_event: assert property ( // R16
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_EVENT_IN.neg_fault |=> event_q[EV_NEG]
    ) else $error("negotiation fault not latched");

    a_conv_event: assert property ( // R20
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_EVENT_IN.converter_fault |=> event_q[EV_CONV]
    ) else $error("converter fault not latched");

    a_fcar_unmasked: assert property ( // R14
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        PHY_EVENT_IN.false_carrier && !mask_q[EV_FCAR]
        |=> event_q[EV_FCAR]
    ) else $error("disabled event not recorded");

    a_energy_live: assert property ( // R21
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        1'b1 |=> event_q[EV_ENERGY] == $past(PHY_EVENT_IN.energy_fault)
    ) else $error("energy fault bit wrong");

    a_wake_live: assert property ( // R22
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        1'b1 |=> event_q[EV_WAKE] == $past(PHY_EVENT_IN.wake)
    ) else $error("wake bit wrong");

    a_link_bit: assert property ( // R05
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_live_w |=> AVS_READDATA_OUT[10] == $past(PHY_STATE_IN.link_up)
    ) else $error("link bit wrong");

    a_pair_pol: assert property ( // R08
        @(posedge MCLK_IN) disable iff (!NRST_IN)
        rd_live_w && !(PHY_STATE_IN.link_up && PHY_STATE_IN.rate == RATE_1000)
        |=> AVS_READDATA_OUT[5:2] == 4'h0
    ) else $error("pair polarity shown off gigabit");

endmodule

// file: verification/psirq_station.sv
`timescale 1ns/1ps
// ----
// register bus master model
// ----
module psirq_station (
    input wire logic clk_in,
    input wire logic wait_in,
    input wire logic [31:0] rdata_in,
    output logic [7:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [3:0] be_out,
    output logic [31:0] wdata_out
);
    initial begin
        addr_out = 8'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        be_out = 4'h0;
        wdata_out = 32'h0;
    end
    // one access, held until waitrequest low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
            input logic [15:0] d, output logic [15:0] q, output bit tmo);
        int n;
        n = 0;
        rd_out <= ~w;
        wr_out <= w;
        addr_out <= a;
        be_out <= be;
        wdata_out <= {16'h0000, d};
        @(posedge clk_in);
        while (wait_in !== 1'b0 && n < 16) begin
            @(posedge clk_in);
            n++;
        end
        tmo = (n >= 16);
        q = rdata_in[15:0];
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // released lines stop showing the old value
        addr_out <= ~a;
        wdata_out <= ~wdata_out;
        @(posedge clk_in);
    endtask
endmodule

// file: verification/link_state_report_and_interrupt_regs_tb.sv
`timescale 1ns/1ps
module link_state_report_and_interrupt_regs_tb;
    import psirq_pkg::*;
    logic clk;
    logic nrst;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
    psirq_phy_s ph;
    psirq_evt_s ev;
    int num_errors = 0;
    int checks = 0;
    int seed = 32'hE5A3B194;
    logic [31:0] r;
    logic [15:0] q;
    logic [15:0] m;
    psirq_phy_s pv;
    int pe[5] = '{7, 6, 5, 4, 3};
    int pb[5] = '{15, 12, 8, 7, 5};
    logic [16:0] tg[8] = '{17'h08000, 17'h04000, 17'h01000, 17'h00400, 17'h00200,
        17'h00040, 17'h00002, 17'h00001};
    int cb[8] = '{14, 13, 11, 10, 6, 4, 1, 0};
    logic [15:0] im[6] = '{16'h8000, 16'h8000, 16'h4000, 16'h8000, 16'h0000, 16'h8000};
    logic [15:0] ic[6] = '{16'h0000, 16'h0001, 16'h0001, 16'h2001, 16'h2001, 16'h2000};
    logic io[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

    psirq_top DUT (.MCLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(be), .AVS_WRITEDATA_IN(wdata),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .PHY_STATE_IN(ph),
        .PHY_EVENT_IN(ev), .IRQ_OUT(irq));
    psirq_station st (.clk_in(clk), .wait_in(waitreq), .rdata_in(rdata), .addr_out(addr),
        .rd_out(rd), .wr_out(wr), .be_out(be), .wdata_out(wdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----
    // expectations and checks
    // ----
    function automatic logic [15:0] exp_live(psirq_phy_s p, logic pg);
        exp_live = {p.rate, p.full_half, pg, ~p.an_enabled | p.an_done, p.link_up,
            p.mdix_cd, p.mdix_ab, p.downshift & p.an_active, p.sleep,
            (p.link_up && p.rate == RATE_1000) ? p.wire_pol : 4'h0, p.pol10, p.babble};
    endfunction
    task automatic conclude();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t irq got %b exp %b", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
            input logic [15:0] d);
        bit t;
        st.xfer(w, a, b, d, q, t);
        if (t) begin
            num_errors++;
            $display("[FAIL] %0t bus timeout", $time);
            conclude();
        end
    endtask
    task automatic wrt(input logic [7:0] a, input logic [3:0] b, input logic [15:0] d);
        acc(1'b1, a, b, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        acc(1'b0, a, 4'hF, 16'h0000);
        chk16(q, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        nrst = 1'b0;
        ph = '0;
        ev = '0;
        cyc(5);
        nrst <= 1'b1;
        @(posedge clk);
        rdc(8'h44, exp_live(ph, 1'b0));
        rdc(8'h48, 16'h0000);
        rdc(8'h4C, 16'h0000);
        done("reset");
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            if (i < 4) r[16:15] = i[1:0];
            if (i < 4) r[10] = 1'b1;
            pv = psirq_phy_s'(r[16:0]);
            ph <= pv;
            rdc(8'h44, exp_live(pv, 1'b0));
        end
        ph <= '0;
        cyc(3);
        acc(1'b0, 8'h4C, 4'hF, 16'h0000);
        done("live");
        for (int i = 0; i < 5; i++) begin
            ev <= psirq_evt_s'(8'(1 << pe[i]));
            @(posedge clk);
            ev <= '0;
            cyc(2);
            rdc(8'h4C, 16'(1 << pb[i]));
            rdc(8'h4C, 16'h0000);
            rdc(8'h44, exp_live(ph, i == 1));
            rdc(8'h44, exp_live(ph, 1'b0));
        end
        for (int i = 0; i < 8; i++) begin
            ph <= psirq_phy_s'(ph ^ tg[i]);
            cyc(3);
            rdc(8'h4C, 16'(1 << cb[i]));
        end
        ev <= psirq_evt_s'(8'h07);
        cyc(3);
        rdc(8'h4C, 16'h020C);
        rdc(8'h4C, 16'h020C);
        ev <= '0;
        cyc(3);
        rdc(8'h4C, 16'h0000);
        done("events");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wrt(8'h48, 4'hF, r[15:0]);
            rdc(8'h48, r[15:0]);
            wrt(8'h48, 4'h1 << i[0], r[31:16]);
            m = i[0] ? {r[31:24], r[7:0]} : {r[15:8], r[23:16]};
            rdc(8'h48, m);
        end
        wrt(8'h40, 4'hF, 16'hFFFF);
        rdc(8'h40, 16'h0000);
        wrt(8'h4C, 4'hF, 16'hFFFF);
        rdc(8'h4C, 16'h0000);
        done("mask");
        // fault already latched, so the read clears the very bit that is set again
        ev <= psirq_evt_s'(8'h80);
        @(posedge clk);
        ev <= '0;
        cyc(2);
        fork
            rdc(8'h4C, 16'h8000);
            begin
                @(posedge clk);
                ev <= psirq_evt_s'(8'h80);
                @(posedge clk);
                ev <= '0;
            end
        join
        rdc(8'h4C, 16'h8000);
        done("race");
        ev <= psirq_evt_s'(8'h80);
        @(posedge clk);
        ev <= '0;
        for (int i = 0; i < 6; i++) begin
            wrt(8'h48, 4'hF, im[i]);
            wrt(8'h60, 4'hF, ic[i]);
            cyc(2);
            chk1(irq, io[i]);
        end
        rdc(8'h4C, 16'h8000);
        wrt(8'h60, 4'hF, 16'h0001);
        cyc(2);
        chk1(irq, 1'b0);
        rdc(8'h60, 16'h0001);
        done("irq");
        conclude();
    end
endmodule
